//--- breakpoint_regs.vh
// register indices, field positions, reset values and encodings of the breakpoint debug unit
// Functional notes
// - access type 00 execute only, 01 data write only, 11 read or write, 10 unused
// - span length 00 one byte, 01 two bytes, 11 four bytes, 10 unused
// - global arm bit keeps breakpoint armed in all tasks; never cleared on task switch
// - local arm bit arms for current task only; cleared on every task switch
// - access guard blocks debug register moves; cleared when any debug exception taken
// - match flag set for each matching breakpoint at an exception, even if unarmed
// - task trap flag set before handler when switching to task with trap bit set
// - single step flag set when exception caused by trap flag, flags bit 8
// - status flags never cleared by hardware; handler software clears them by writing
// - with trap flag set, a debug exception follows every completed instruction
// - one-byte software breakpoint instruction also raises a code breakpoint exception
// - four read/write address registers hold linear breakpoint addresses
// - status captures the conditions present at the moment of the exception
// - execute breakpoints are raised before the matching instruction executes
// - debug registers moved only by move instructions at privilege level 0
`ifndef BREAKPOINT_REGS_VH
`define BREAKPOINT_REGS_VH
// register indices on the move port
`define IDX_ADDR0       3'h0
`define IDX_ADDR1       3'h1
`define IDX_ADDR2       3'h2
`define IDX_ADDR3       3'h3
`define IDX_STATUS      3'h6
`define IDX_CONTROL     3'h7
// control field positions
`define CTL_GUARD_BIT   13
`define CTL_TYPE_LSB    16
`define CTL_LEN_LSB     18
`define CTL_FIELD_STEP  4
// control reserved bits and reset
`define CTL_WMASK       32'hffff20ff
`define CTL_FIXED       32'h00000400
`define CTL_RESET       32'h00000400
// status field positions, reserved bits and reset
`define STS_STEP_BIT    14
`define STS_TASK_BIT    15
`define STS_WMASK       32'h0000c00f
`define STS_FIXED       32'h00001ff0
`define STS_RESET       32'h00001ff0
`define ADDR_RESET      32'h00000000
// access type encodings
`define TYPE_EXEC       2'h0
`define TYPE_WRITE      2'h1
`define TYPE_UNUSED     2'h2
`define TYPE_RDWR       2'h3
// span length encodings
`define LEN_ONE         2'h0
`define LEN_TWO         2'h1
`define LEN_UNUSED      2'h2
`define LEN_FOUR        2'h3
// flags register trap flag position
`define FLAG_TRAP_BIT   8
`endif

//--- breakpoint_debug_unit.v
// breakpoint, single-step and debug register logic beside the core pipeline
`timescale 1ns/100ps
`default_nettype none
`include "breakpoint_regs.vh"

module breakpoint_debug_unit #(
  parameter NUM_BP = 4
) (
  input  wire        clk,
  input  wire        rst_n,
  // debug register move port
  input  wire        move_rd,
  input  wire        move_wr,
  input  wire [2:0]  move_index,
  input  wire [31:0] move_wdata,
  input  wire [1:0]  current_privilege,
  output reg  [31:0] move_rdata,
  output reg         move_done,
  output reg         move_priv_fault,
  output reg         move_guard_fault,
  // instruction fetch side
  input  wire        fetch_valid,
  input  wire [31:0] fetch_addr,
  output wire        exec_break,
  // data access side
  input  wire        data_valid,
  input  wire        data_write,
  input  wire [31:0] data_addr,
  input  wire [1:0]  data_len,
  // instruction completion and flags
  input  wire        instr_retire,
  input  wire [31:0] flags_register,
  input  wire        software_breakpoint_instruction,
  // task switch
  input  wire        task_switch,
  input  wire        task_trap_bit,
  // exception towards the core
  output reg         debug_exception,
  output wire [31:0] breakpoint_control_out,
  output wire [31:0] breakpoint_status_out
);

  reg  [31:0] breakpoint_address_regs [0:NUM_BP-1];
  reg  [31:0] breakpoint_control;
  reg  [31:0] breakpoint_status;
  wire [NUM_BP-1:0] match_flag;
  wire [NUM_BP-1:0] armed;
  wire [NUM_BP-1:0] exec_match;
  wire [NUM_BP-1:0] data_match;
  wire        step_event;
  wire        task_trap_event;
  wire        move_req;
  wire        priv_ok;
  wire        guard_hit;
  wire        move_ok;
  wire        take_exception;
  wire        data_break;
  wire [2:0]  write_sel;
  wire        write_address;
  wire        write_status;
  wire        write_control;
  reg  [31:0] next_control;
  reg  [31:0] next_status;
  integer     k;
  integer     m; // reset loop index, kept apart from the combinational one

  // byte lanes covered by an address and a span length, within one dword
  function [3:0] byte_lanes;
    input [1:0] low;
    input [1:0] len;
    reg   [3:0] base;
    begin
      base = 4'h1;
      case (len)
        `LEN_ONE: begin
          base = 4'h1;
        end
        `LEN_TWO: begin
          base = 4'h3;
        end
        `LEN_FOUR: begin
          base = 4'hf;
        end
        default: begin
          base = 4'h1;
        end
      endcase
      byte_lanes = base << low;
    end
  endfunction

  // breakpoint address is assumed aligned to its span
  function [1:0] aligned_low;
    input [1:0] low;
    input [1:0] len;
    begin
      case (len)
        `LEN_TWO: begin
          aligned_low = {low[1], 1'b0};
        end
        `LEN_FOUR: begin
          aligned_low = 2'h0;
        end
        default: begin
          aligned_low = low;
        end
      endcase
    end
  endfunction

  // register group decode: bit 2 control, bit 1 status, bit 0 an address register
  function [2:0] reg_select;
    input [2:0] index;
    begin
      reg_select = 3'h0;
      if (index == `IDX_CONTROL) begin
        reg_select = 3'h4;
      end else if (index == `IDX_STATUS) begin
        reg_select = 3'h2;
      end else if (index < NUM_BP) begin
        reg_select = 3'h1;
      end
    end
  endfunction

  // per-breakpoint comparators
  genvar i;
  generate
    for (i = 0; i < NUM_BP; i = i + 1) begin : g_bp
      wire [1:0]  bp_type;
      wire [1:0]  bp_len;
      wire [31:0] bp_addr;
      wire [3:0]  bp_lanes;
      wire [3:0]  acc_lanes;
      wire        same_dword;
      assign bp_type = breakpoint_control[`CTL_TYPE_LSB + i*`CTL_FIELD_STEP +: 2];
      assign bp_len  = breakpoint_control[`CTL_LEN_LSB + i*`CTL_FIELD_STEP +: 2];
      assign bp_addr = breakpoint_address_regs[i];
      assign bp_lanes   = byte_lanes(aligned_low(bp_addr[1:0], bp_len), bp_len);
      assign acc_lanes  = byte_lanes(data_addr[1:0], data_len);
      assign same_dword = (data_addr[31:2] == bp_addr[31:2]);
      assign exec_match[i] = fetch_valid && (bp_type == `TYPE_EXEC) &&
                             (fetch_addr == bp_addr);
      // data write or any data access
      assign data_match[i] = data_valid && same_dword && ((bp_lanes & acc_lanes) != 4'h0) &&
                             (((bp_type == `TYPE_WRITE) && data_write) ||
                              (bp_type == `TYPE_RDWR));
      assign match_flag[i] = exec_match[i] || data_match[i];
      assign armed[i] = breakpoint_control[2*i] || breakpoint_control[2*i+1];
    end
  endgenerate

  assign step_event      = instr_retire && flags_register[`FLAG_TRAP_BIT];
  assign task_trap_event = task_switch && task_trap_bit;

  // raised combinationally so the core stops before execution
  assign exec_break = |(exec_match & armed);

  // moves only at privilege level 0
  assign move_req  = move_rd || move_wr;
  assign priv_ok   = (current_privilege == 2'h0);
  assign guard_hit = move_req && priv_ok && breakpoint_control[`CTL_GUARD_BIT];
  assign move_ok   = move_req && priv_ok && !breakpoint_control[`CTL_GUARD_BIT];

  // accepted writes, one strobe per register group
  assign write_sel     = reg_select(move_index);
  assign write_address = move_ok && move_wr && write_sel[0];
  assign write_status  = move_ok && move_wr && write_sel[1];
  assign write_control = move_ok && move_wr && write_sel[2];

  // armed data breakpoints only; unarmed matches are logged only at an exception, not raised
  assign data_break = |(data_match & armed);

  // software breakpoint is a cause of its own
  assign take_exception = exec_break || data_break || step_event ||
                          task_trap_event || software_breakpoint_instruction || guard_hit;

  // next control value: write, then task switch, then exception
  always @* begin
    next_control = breakpoint_control;
    if (write_control) begin
      // reserved bits forced to their fixed values
      next_control = (move_wdata & `CTL_WMASK) | `CTL_FIXED;
    end
    if (task_switch) begin
      // local arm bits dropped, global kept
      for (k = 0; k < NUM_BP; k = k + 1) begin
        next_control[2*k] = 1'b0;
      end
    end
    if (take_exception) begin
      next_control[`CTL_GUARD_BIT] = 1'b0;
    end
  end

  // next status value: hardware sets win over a software clear in the same cycle
  always @* begin
    next_status = breakpoint_status;
    if (write_status) begin
      next_status = (move_wdata & `STS_WMASK) | `STS_FIXED;
    end
    if (take_exception) begin
      next_status[NUM_BP-1:0] = next_status[NUM_BP-1:0] | match_flag;
      if (step_event) begin
        next_status[`STS_STEP_BIT] = 1'b1;
      end
      if (task_trap_event) begin
        next_status[`STS_TASK_BIT] = 1'b1;
      end
    end
  end

  // control and status registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      breakpoint_control <= `CTL_RESET;
      breakpoint_status  <= `STS_RESET;
    end else begin
      breakpoint_control <= next_control;
      breakpoint_status  <= next_status;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (m = 0; m < NUM_BP; m = m + 1) begin
        breakpoint_address_regs[m] <= `ADDR_RESET;
      end
    end else if (write_address) begin
      breakpoint_address_regs[move_index[1:0]] <= move_wdata;
    end
  end

  // move read data and completion, one cycle after the request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      move_rdata       <= 32'h00000000;
      move_done        <= 1'b0;
      move_priv_fault  <= 1'b0;
      move_guard_fault <= 1'b0;
    end else begin
      move_done        <= move_ok;
      move_priv_fault  <= move_req && !priv_ok;
      move_guard_fault <= guard_hit;
      // refused moves leave the read data untouched
      if (move_ok && move_rd) begin
        case (move_index)
          `IDX_ADDR0: begin
            move_rdata <= breakpoint_address_regs[0];
          end
          `IDX_ADDR1: begin
            move_rdata <= breakpoint_address_regs[1];
          end
          `IDX_ADDR2: begin
            move_rdata <= breakpoint_address_regs[2];
          end
          `IDX_ADDR3: begin
            move_rdata <= breakpoint_address_regs[3];
          end
          `IDX_STATUS: begin
            move_rdata <= breakpoint_status;
          end
          `IDX_CONTROL: begin
            move_rdata <= breakpoint_control;
          end
          default: begin
            move_rdata <= 32'h00000000; // unmapped index reads zero
          end
        endcase
      end
    end
  end

  // exception pulse to the core, one cycle after its cause
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_exception <= 1'b0;
    end else begin
      debug_exception <= take_exception;
    end
  end

  // register views for the core
  assign breakpoint_control_out = breakpoint_control;
  assign breakpoint_status_out  = breakpoint_status;

endmodule
`default_nettype wire

//--- breakpoint_debug_unit_chk.sv
// port assertions for the breakpoint debug unit
`timescale 1ns/100ps
`default_nettype none
module breakpoint_debug_unit_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        move_rd,
  input wire logic        move_wr,
  input wire logic [1:0]  current_privilege,
  input wire logic        move_done,
  input wire logic        move_priv_fault,
  input wire logic        instr_retire,
  input wire logic [31:0] flags_register,
  input wire logic        software_breakpoint_instruction,
  input wire logic        task_switch,
  input wire logic        task_trap_bit,
  input wire logic        debug_exception,
  input wire logic [31:0] breakpoint_control_out,
  input wire logic [31:0] breakpoint_status_out
);
  // single core clock, reset silences every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_step; instr_retire && flags_register[8] |=> debug_exception && breakpoint_status_out[14]; endproperty
  a_step: assert property (p_step) else $error("step gave no flagged exception");
  property p_guard; debug_exception |-> !breakpoint_control_out[13]; endproperty
  a_guard: assert property (p_guard) else $error("guard kept after exception");
  property p_task; task_switch && task_trap_bit |=> debug_exception && breakpoint_status_out[15]; endproperty
  a_task: assert property (p_task) else $error("task trap not flagged");
  property p_local; task_switch |=> (breakpoint_control_out & 32'h55) == 32'h0; endproperty
  a_local: assert property (p_local) else $error("local arm kept over switch");
  // global bits compared against the value before the switch
  property p_global; task_switch && !move_wr |=> (breakpoint_control_out & 32'haa) == ($past(breakpoint_control_out) & 32'haa); endproperty
  a_global: assert property (p_global) else $error("global arm lost on switch");
  property p_sticky; !move_wr |=> (breakpoint_status_out & $past(breakpoint_status_out)) == $past(breakpoint_status_out); endproperty
  a_sticky: assert property (p_sticky) else $error("status flag cleared by hardware");
  property p_priv; (move_rd || move_wr) && current_privilege != 2'h0 |=> move_priv_fault && !move_done; endproperty
  a_priv: assert property (p_priv) else $error("move accepted above level zero");
  property p_swbp; software_breakpoint_instruction |=> debug_exception; endproperty
  a_swbp: assert property (p_swbp) else $error("software breakpoint ignored");
  // main scenarios reached
  c_step: cover property (instr_retire && flags_register[8]);
  c_task: cover property (task_switch && task_trap_bit);
  c_guard: cover property (move_rd && breakpoint_control_out[13]);
endmodule
bind breakpoint_debug_unit breakpoint_debug_unit_chk chk (.clk(clk), .rst_n(rst_n), .move_rd(move_rd),
  .move_wr(move_wr), .current_privilege(current_privilege), .move_done(move_done),
  .move_priv_fault(move_priv_fault), .instr_retire(instr_retire), .flags_register(flags_register),
  .software_breakpoint_instruction(software_breakpoint_instruction), .task_switch(task_switch),
  .task_trap_bit(task_trap_bit), .debug_exception(debug_exception),
  .breakpoint_control_out(breakpoint_control_out), .breakpoint_status_out(breakpoint_status_out));
`default_nettype wire

//--- core_model.sv
// behavioural core pipeline feeding the unit's move, fetch, data and event inputs
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic  clk,
  input  wire logic  exec_break,
  output logic       move_rd,
  output logic       move_wr,
  output logic [2:0] move_index,
  output logic [31:0] move_wdata,
  output logic [1:0] current_privilege,
  output logic       fetch_valid,
  output logic [31:0] fetch_addr,
  output logic       data_valid,
  output logic       data_write,
  output logic [31:0] data_addr,
  output logic [1:0] data_len,
  output logic       instr_retire,
  output logic [31:0] flags_register,
  output logic       software_breakpoint_instruction,
  output logic       task_switch,
  output logic       task_trap_bit
);
  logic hit;
  // idle core at time zero
  initial begin
    {move_rd, move_wr, move_index, move_wdata, current_privilege, fetch_valid, fetch_addr} = '0;
    {data_valid, data_write, data_addr, data_len, instr_retire, software_breakpoint_instruction} = '0;
    {task_switch, task_trap_bit, hit} = '0;
    flags_register = 32'h2;
  end
  // one move, held across exactly one rising edge; released data inverted
  task mv(input logic w, input logic [2:0] i, input logic [31:0] d, input logic [1:0] p);
    @(negedge clk);
    {move_rd, move_wr, move_index, move_wdata, current_privilege} = {!w, w, i, d, p};
    @(negedge clk);
    {move_rd, move_wr} = 2'b00;
    move_wdata = ~d;
  endtask
  // one pipeline cycle: k = tf, trap, switch, sw bkpt, retire, data, fetch
  task ev(input logic [6:0] k, input logic [31:0] a, input logic w, input logic [1:0] l);
    @(negedge clk);
    {task_trap_bit, task_switch, software_breakpoint_instruction, instr_retire, data_valid, fetch_valid} = k[5:0];
    flags_register = {23'h0, k[6], 8'h02};
    {fetch_addr, data_addr, data_write, data_len} = {a, a, w, l};
    @(posedge clk);
    hit = exec_break;
    @(negedge clk);
    {task_trap_bit, task_switch, software_breakpoint_instruction, instr_retire, data_valid, fetch_valid} = 6'h0;
    flags_register = 32'h2;
    fetch_addr = ~a;
    data_addr = ~a;
  endtask
endmodule
`default_nettype wire

//--- breakpoint_debug_unit_test.sv
// self-checking bench for the breakpoint debug unit
`timescale 1ns/100ps
`default_nettype none
`include "breakpoint_regs.vh"
module breakpoint_debug_unit_test;
  logic        clk, rst_n, move_rd, move_wr, fetch_valid, data_valid, data_write, instr_retire, task_switch;
  logic        software_breakpoint_instruction, task_trap_bit, exec_break, move_done, debug_exception;
  logic        move_priv_fault, move_guard_fault;
  logic [1:0]  current_privilege, data_len;
  logic [2:0]  move_index;
  logic [31:0] move_wdata, fetch_addr, data_addr, flags_register, move_rdata;
  int          mismatches, checks_done;
  core_model core (.clk(clk), .exec_break(exec_break), .move_rd(move_rd), .move_wr(move_wr),
    .move_index(move_index), .move_wdata(move_wdata), .current_privilege(current_privilege),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .data_valid(data_valid), .data_write(data_write),
    .data_addr(data_addr), .data_len(data_len), .instr_retire(instr_retire), .flags_register(flags_register),
    .software_breakpoint_instruction(software_breakpoint_instruction), .task_switch(task_switch),
    .task_trap_bit(task_trap_bit));
  breakpoint_debug_unit dut (.clk(clk), .rst_n(rst_n), .move_rd(move_rd), .move_wr(move_wr),
    .move_index(move_index), .move_wdata(move_wdata), .current_privilege(current_privilege),
    .move_rdata(move_rdata), .move_done(move_done), .move_priv_fault(move_priv_fault),
    .move_guard_fault(move_guard_fault), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .exec_break(exec_break), .data_valid(data_valid), .data_write(data_write), .data_addr(data_addr),
    .data_len(data_len), .instr_retire(instr_retire), .flags_register(flags_register),
    .software_breakpoint_instruction(software_breakpoint_instruction), .task_switch(task_switch),
    .task_trap_bit(task_trap_bit), .debug_exception(debug_exception), .breakpoint_control_out(),
    .breakpoint_status_out());
  // 20 MHz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare, count, report a miss at once
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // register moves at level zero
  task rd(input logic [2:0] i, input logic [31:0] e);
    core.mv(1'b0, i, 32'h0, 2'h0);
    chk("move_done", 32'(move_done), 32'h1);
    chk("move_rdata", move_rdata, e);
  endtask
  task wr(input logic [2:0] i, input logic [31:0] d);
    core.mv(1'b1, i, d, 2'h0);
  endtask
  task give_verdict;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, a run this long is a miss
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict;
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rd(3'h7, `CTL_RESET);
    rd(3'h6, `STS_RESET);
    for (int i = 0; i < 4; i++) begin
      rd(i[2:0], `ADDR_RESET);
      wr(i[2:0], 32'h0a0b0c00 + i);
      rd(i[2:0], 32'h0a0b0c00 + i);
    end
    rd(3'h4, 32'h0);
    core.mv(1'b1, 3'h0, 32'h1000, 2'h3);
    chk("move_priv_fault", 32'(move_priv_fault), 32'h1);
    rd(3'h0, 32'h0a0b0c00);
    wr(3'h0, 32'h1000);
    wr(3'h7, 32'h401);
    core.ev(7'h01, 32'h1000, 1'b0, 2'h0);
    chk("exec_break", 32'(core.hit & debug_exception), 32'h1);
    rd(3'h6, 32'h1ff1);
    core.ev(7'h01, 32'h1001, 1'b0, 2'h0);
    chk("exec_break", 32'(core.hit), 32'h0);
    wr(3'h1, 32'h2000);
    // every access type against a write and a read at the span base
    for (int t = 0; t < 4; t++)
      for (int w = 0; w < 2; w++) begin
        wr(3'h7, 32'h404 | (t << 20) | (3 << 22));
        core.ev(7'h02, 32'h2000, w[0], 2'h0);
        chk("data_hit", 32'(debug_exception), 32'((t == 3) || (t == 1 && w == 1)));
      end
    // byte one and three of the span under each used length
    for (int l = 0; l < 4; l++)
      for (int o = 1; o < 4; o += 2)
        if (l != 2) begin
          wr(3'h7, 32'h404 | (3 << 20) | (l << 22));
          core.ev(7'h02, 32'h2000 + o, 1'b1, 2'h0);
          chk("span_hit", 32'(debug_exception), 32'((l == 3) || (l == 1 && o == 1)));
        end
    // wider accesses: two bytes at byte two, four bytes at the base
    for (int l = 0; l < 4; l++)
      if (l != 2) begin
        wr(3'h7, 32'h404 | (3 << 20) | (l << 22));
        core.ev(7'h02, 32'h2002, 1'b0, 2'h1);
        chk("span_wide", 32'(debug_exception), 32'(l == 3));
        core.ev(7'h02, 32'h2000, 1'b0, 2'h3);
        chk("span_wide", 32'(debug_exception), 32'h1);
      end
    // odd breakpoint address is taken as aligned to its two-byte span
    wr(3'h1, 32'h2001);
    wr(3'h7, 32'h404 | (3 << 20) | (1 << 22));
    core.ev(7'h02, 32'h2000, 1'b0, 2'h0);
    chk("span_align", 32'(debug_exception), 32'h1);
    wr(3'h7, 32'h400);
    wr(3'h2, 32'h3000);
    wr(3'h6, 32'h0);
    core.ev(7'h04, 32'h3000, 1'b0, 2'h0);
    chk("debug_exception", 32'(debug_exception), 32'h0);
    core.ev(7'h45, 32'h3000, 1'b0, 2'h0);
    chk("exec_break", 32'(core.hit), 32'h0);
    rd(3'h6, 32'h5ff4);
    core.ev(7'h00, 32'h0, 1'b0, 2'h0);
    rd(3'h6, 32'h5ff4);
    wr(3'h6, 32'h0);
    rd(3'h6, `STS_RESET);
    // local arm bits dropped on a task switch, global kept
    wr(3'h7, 32'h4ff);
    core.ev(7'h10, 32'h0, 1'b0, 2'h0);
    chk("debug_exception", 32'(debug_exception), 32'h0);
    rd(3'h7, 32'h4aa);
    core.ev(7'h30, 32'h0, 1'b0, 2'h0);
    rd(3'h6, 32'h9ff0);
    core.ev(7'h08, 32'h0, 1'b0, 2'h0);
    chk("debug_exception", 32'(debug_exception), 32'h1);
    wr(3'h7, 32'hffffffff);
    core.mv(1'b0, 3'h7, 32'h0, 2'h0);
    chk("move_guard_fault", 32'(move_guard_fault & debug_exception), 32'h1);
    rd(3'h7, 32'hffff04ff);
    give_verdict;
  end
endmodule
`default_nettype wire
